// *** verilog/smsc_pkg.sv ***
`default_nettype none
package smsc_pkg;

    // Strap level bins, as reported by the strap comparators.
    typedef enum logic [1:0] {
        SMSC_BIN_SHORT = 2'h0,
        SMSC_BIN_MID   = 2'h1,
        SMSC_BIN_HIGH  = 2'h2,
        SMSC_BIN_OPEN  = 2'h3
    } smsc_bin_t;

    typedef enum logic [1:0] {
        SMSC_MODE_TABLE1 = 2'h0,
        SMSC_MODE_TABLE2 = 2'h1,
        SMSC_MODE_NOSLP  = 2'h2
    } smsc_mode_t;

    typedef struct packed {
        logic       valid;
        logic       sleep_en;
        smsc_mode_t mode;
        smsc_bin_t  en_bin;
        smsc_bin_t  thr_bin;
        logic [6:0] entry_duty;
        logic [6:0] exit_duty;
    } smsc_cfg_t;

    // Wishbone register offsets (byte addresses).
    localparam logic [3:0] SMSC_OFF_CTRL = 4'h0;
    localparam logic [3:0] SMSC_OFF_CFG = 4'h4;
    localparam logic [3:0] SMSC_OFF_STAT = 4'h8;
    localparam logic [3:0] SMSC_OFF_DUTY = 4'hC;

    // CTRL field positions.
    localparam int SMSC_CTRL_STANDBY_BIT = 0;
    localparam logic [31:0] SMSC_CTRL_RESET = 32'h0;

    // Duty thresholds in percent.
    localparam logic [6:0] SMSC_T1_ENTRY = 7'h28;
    localparam logic [6:0] SMSC_T2_ENTRY = 7'h19;
    localparam logic [6:0] SMSC_NOSLP_ENTRY = 7'h00;
    localparam logic [6:0] SMSC_T1_EXIT_SHORT = 7'h50;
    localparam logic [6:0] SMSC_T1_EXIT_MID = 7'h4B;
    localparam logic [6:0] SMSC_T1_EXIT_HIGH = 7'h41;
    localparam logic [6:0] SMSC_T1_EXIT_OPEN = 7'h3C;
    localparam logic [6:0] SMSC_T2_EXIT_SHORT = 7'h4B;
    localparam logic [6:0] SMSC_T2_EXIT_MID = 7'h46;
    localparam logic [6:0] SMSC_T2_EXIT_HIGH = 7'h3C;
    localparam logic [6:0] SMSC_T2_EXIT_OPEN = 7'h37;
    localparam logic [6:0] SMSC_BM_EXIT_SHORT = 7'h50;
    localparam logic [6:0] SMSC_BM_EXIT_MID = 7'h4B;
    localparam logic [6:0] SMSC_BM_EXIT_HIGH = 7'h41;
    localparam logic [6:0] SMSC_BM_EXIT_OPEN = 7'h00;

    // Half-switching cycles of low duty needed to confirm sleep entry.
    localparam int SMSC_SLEEP_CONFIRM = 512;
    // Half-switching cycles during which timing is ignored after entry.
    localparam int SMSC_SLEEP_BLANK = 8;
    // Clock cycles the strap sources settle before sampling.
    localparam int SMSC_STRAP_SETTLE = 16;

endpackage
`default_nettype wire

// *** verilog/smsc_strap_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module smsc_strap_decode (
    input wire smsc_pkg::smsc_bin_t en_bin_i,
    input wire smsc_pkg::smsc_bin_t thr_bin_i,
    output var smsc_pkg::smsc_cfg_t cfg_o
);
    always_comb begin
        cfg_o = '0;
        cfg_o.valid = 1'b1;
        cfg_o.en_bin = en_bin_i;
        cfg_o.thr_bin = thr_bin_i;
        // R9 - open strap disables
        if (en_bin_i == smsc_pkg::SMSC_BIN_OPEN) begin
            cfg_o.sleep_en = 1'b0;
            cfg_o.mode = smsc_pkg::SMSC_MODE_NOSLP;
            cfg_o.entry_duty = smsc_pkg::SMSC_NOSLP_ENTRY;
            // R12 - burst exit table
            unique case (thr_bin_i)
                smsc_pkg::SMSC_BIN_SHORT: cfg_o.exit_duty = smsc_pkg::SMSC_BM_EXIT_SHORT;
                smsc_pkg::SMSC_BIN_MID: cfg_o.exit_duty = smsc_pkg::SMSC_BM_EXIT_MID;
                smsc_pkg::SMSC_BIN_HIGH: cfg_o.exit_duty = smsc_pkg::SMSC_BM_EXIT_HIGH;
                smsc_pkg::SMSC_BIN_OPEN: cfg_o.exit_duty = smsc_pkg::SMSC_BM_EXIT_OPEN;
            endcase
        // R6 - table select
        end else if (en_bin_i == smsc_pkg::SMSC_BIN_HIGH) begin
            cfg_o.sleep_en = 1'b1;
            cfg_o.mode = smsc_pkg::SMSC_MODE_TABLE2;
            // R8 - second table
            cfg_o.entry_duty = smsc_pkg::SMSC_T2_ENTRY;
            unique case (thr_bin_i)
                smsc_pkg::SMSC_BIN_SHORT: cfg_o.exit_duty = smsc_pkg::SMSC_T2_EXIT_SHORT;
                smsc_pkg::SMSC_BIN_MID: cfg_o.exit_duty = smsc_pkg::SMSC_T2_EXIT_MID;
                smsc_pkg::SMSC_BIN_HIGH: cfg_o.exit_duty = smsc_pkg::SMSC_T2_EXIT_HIGH;
                smsc_pkg::SMSC_BIN_OPEN: cfg_o.exit_duty = smsc_pkg::SMSC_T2_EXIT_OPEN;
            endcase
        end else begin
            // Short and mid enable straps both select the first table.
            cfg_o.sleep_en = 1'b1;
            cfg_o.mode = smsc_pkg::SMSC_MODE_TABLE1;
            // R7 - first table
            cfg_o.entry_duty = smsc_pkg::SMSC_T1_ENTRY;
            unique case (thr_bin_i)
                smsc_pkg::SMSC_BIN_SHORT: cfg_o.exit_duty = smsc_pkg::SMSC_T1_EXIT_SHORT;
                smsc_pkg::SMSC_BIN_MID: cfg_o.exit_duty = smsc_pkg::SMSC_T1_EXIT_MID;
                smsc_pkg::SMSC_BIN_HIGH: cfg_o.exit_duty = smsc_pkg::SMSC_T1_EXIT_HIGH;
                smsc_pkg::SMSC_BIN_OPEN: cfg_o.exit_duty = smsc_pkg::SMSC_T1_EXIT_OPEN;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verilog/smsc_top.sv ***
// Behaviour
// R1 - Capture mode configuration once at supply turn-on; hold it while supply in range.
// R2 - In run, enable below off threshold halts to low power; above on resumes.
// R3 - External on-off switch on enable must stay open during start-up sampling.
// R4 - Source enable strap current; strap up to 180k enables sleep, then lower current.
// R5 - Source threshold strap current, latch entry/exit duties, then switch current off.
// R6 - Enable strap selects table: 100k first table, 180k second table.
// R7 - First table: entry 40%, exit 80/75/65/60% by threshold strap.
// R8 - Second table: entry 25%, exit 75/70/60/55% by threshold strap.
// R9 - Open enable strap latches sleep disabled; no light-load sleep entry.
// R10 - Sleep disabled still sleeps on primary stop or enable pulled low.
// R11 - Resume only once conduction duty exceeds latched exit threshold.
// R12 - Open enable strap: burst exit duty 80/75/65/0% by threshold strap.
// R13 - Sleep enabled: enter after 512 consecutive cycles below entry duty.
// R14 - Each strap encoded as two-bit bin, loaded only at start-up.
`timescale 1ns/1ps
`default_nettype none
module smsc_top #(
    parameter int CONFIRM_CYCLES = smsc_pkg::SMSC_SLEEP_CONFIRM,
    parameter int BLANK_CYCLES = smsc_pkg::SMSC_SLEEP_BLANK,
    parameter int SETTLE_CYCLES = smsc_pkg::SMSC_STRAP_SETTLE
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic half_cycle_i,
    input wire logic [6:0] duty_i,
    input wire logic primary_stop_i,
    input wire logic enable_high_i,
    input wire logic enable_low_i,
    input wire logic [1:0] enable_strap_bin_i,
    input wire logic [1:0] threshold_strap_bin_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic enable_strap_current_o,
    output logic enable_run_current_o,
    output logic threshold_strap_current_o,
    output logic drive_enable_o,
    output logic low_power_o,
    output logic sleep_en_o,
    output logic [6:0] burst_exit_duty_o
);
    typedef enum logic [2:0] {
        SMSC_ST_OFF,
        SMSC_ST_SAMPLE,
        SMSC_ST_RUN,
        SMSC_ST_SLEEP,
        SMSC_ST_REMOTE_OFF
    } smsc_state_t;

    localparam int CNT_W = $clog2(CONFIRM_CYCLES + 1);
    localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
    localparam int BLK_W = $clog2(BLANK_CYCLES + 1);
    localparam logic SMSC_CTRL_RESET_BIT = smsc_pkg::SMSC_CTRL_RESET[0];

    smsc_state_t state_ff;
    smsc_state_t nxt_state;
    smsc_pkg::smsc_cfg_t cfg_ff;
    smsc_pkg::smsc_cfg_t dec_cfg;
    smsc_pkg::smsc_bin_t en_bin_ff;
    smsc_pkg::smsc_bin_t thr_bin_ff;
    logic [SET_W-1:0] settle_ff;
    logic [CNT_W-1:0] low_cnt_ff;
    logic [BLK_W-1:0] blank_ff;
    logic standby_ff;
    logic [31:0] ctrl_rd;
    logic wb_req;
    logic settled;
    logic remote_off_ff;

    smsc_strap_decode u_decode (
        .en_bin_i(en_bin_ff),
        .thr_bin_i(thr_bin_ff),
        .cfg_o(dec_cfg)
    );

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign settled = (settle_ff == SET_W'(SETTLE_CYCLES));

    // Remote on-off with hysteresis: two comparator outputs form the band.
    always_ff @(posedge clk_i) begin
        if (rst_i || !supply_ok_i) begin
            remote_off_ff <= 1'b0;
        // R2 - enable hysteresis
        end else if (enable_low_i) begin
            remote_off_ff <= 1'b1;
        end else if (enable_high_i) begin
            remote_off_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SMSC_ST_OFF: begin
                // R1 - capture at turn-on
                if (supply_ok_i) begin
                    nxt_state = SMSC_ST_SAMPLE;
                end
            end
            SMSC_ST_SAMPLE: begin
                if (settled) begin
                    nxt_state = SMSC_ST_RUN;
                end
            end
            SMSC_ST_RUN: begin
                // R10 - forced low power
                if (remote_off_ff || standby_ff) begin
                    nxt_state = SMSC_ST_REMOTE_OFF;
                end else if (primary_stop_i) begin
                    nxt_state = SMSC_ST_SLEEP;
                // R13 - confirmed light load
                end else if (cfg_ff.sleep_en && half_cycle_i &&
                             low_cnt_ff == CNT_W'(CONFIRM_CYCLES - 1) &&
                             duty_i < cfg_ff.entry_duty) begin
                    nxt_state = SMSC_ST_SLEEP;
                end
            end
            SMSC_ST_SLEEP: begin
                if (remote_off_ff || standby_ff) begin
                    nxt_state = SMSC_ST_REMOTE_OFF;
                // R11 - duty exit check
                end else if (blank_ff == '0 && half_cycle_i && !primary_stop_i &&
                             duty_i > cfg_ff.exit_duty) begin
                    nxt_state = SMSC_ST_RUN;
                end
            end
            SMSC_ST_REMOTE_OFF: begin
                // Resume goes through sleep so the exit duty still gates driving.
                if (!remote_off_ff && !standby_ff) begin
                    nxt_state = SMSC_ST_SLEEP;
                end
            end
        endcase
        if (!supply_ok_i) begin
            nxt_state = SMSC_ST_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= SMSC_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff != SMSC_ST_SAMPLE) begin
            settle_ff <= '0;
        end else if (!settled) begin
            settle_ff <= settle_ff + SET_W'(1);
        end
    end

    // R14 - bins loaded at start-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_bin_ff <= smsc_pkg::SMSC_BIN_OPEN;
            thr_bin_ff <= smsc_pkg::SMSC_BIN_OPEN;
        end else if (state_ff == SMSC_ST_SAMPLE && !settled) begin
            en_bin_ff <= smsc_pkg::smsc_bin_t'(enable_strap_bin_i);
            thr_bin_ff <= smsc_pkg::smsc_bin_t'(threshold_strap_bin_i);
        end
    end

    // R1 - hold config in range
    always_ff @(posedge clk_i) begin
        if (rst_i || !supply_ok_i) begin
            cfg_ff <= '0;
        end else if (state_ff == SMSC_ST_SAMPLE && settled) begin
            cfg_ff <= dec_cfg;
        end
    end

    // R4 - strap current sources
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_strap_current_o <= 1'b0;
            enable_run_current_o <= 1'b0;
            threshold_strap_current_o <= 1'b0;
        end else begin
            enable_strap_current_o <= (nxt_state == SMSC_ST_SAMPLE);
            enable_run_current_o <= (nxt_state != SMSC_ST_SAMPLE) &&
                                    (nxt_state != SMSC_ST_OFF);
            // R5 - source off after store
            threshold_strap_current_o <= (nxt_state == SMSC_ST_SAMPLE);
        end
    end

    // R13 - consecutive low count
    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff != SMSC_ST_RUN) begin
            low_cnt_ff <= '0;
        end else if (half_cycle_i) begin
            if (duty_i < cfg_ff.entry_duty) begin
                low_cnt_ff <= low_cnt_ff + CNT_W'(1);
            end else begin
                low_cnt_ff <= '0;
            end
        end
    end

    // After entry the exit check is ignored for a few cycles to let it settle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blank_ff <= '0;
        end else if (state_ff != SMSC_ST_SLEEP && nxt_state == SMSC_ST_SLEEP) begin
            blank_ff <= BLK_W'(BLANK_CYCLES);
        end else if (half_cycle_i && blank_ff != '0) begin
            blank_ff <= blank_ff - BLK_W'(1);
        end
    end

    // R9 - no light-load sleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_enable_o <= 1'b0;
            low_power_o <= 1'b1;
            sleep_en_o <= 1'b0;
            burst_exit_duty_o <= '0;
        end else begin
            drive_enable_o <= (nxt_state == SMSC_ST_RUN);
            low_power_o <= (nxt_state != SMSC_ST_RUN);
            sleep_en_o <= cfg_ff.sleep_en;
            // R12 - burst exit output
            burst_exit_duty_o <= cfg_ff.exit_duty;
        end
    end

    // Software standby request forces the low-power state like a remote off.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_ff <= SMSC_CTRL_RESET_BIT;
        end else if (wb_req && wb_we_i && wb_adr_i == smsc_pkg::SMSC_OFF_CTRL &&
                     wb_sel_i[0]) begin
            standby_ff <= wb_dat_i[smsc_pkg::SMSC_CTRL_STANDBY_BIT];
        end
    end

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[smsc_pkg::SMSC_CTRL_STANDBY_BIT] = standby_ff;
    end

    // One wait-free cycle: ack follows the request by one edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    smsc_pkg::SMSC_OFF_CTRL: wb_dat_o <= ctrl_rd;
                    smsc_pkg::SMSC_OFF_CFG: wb_dat_o <= {22'h0, cfg_ff.valid,
                        cfg_ff.sleep_en, cfg_ff.mode, cfg_ff.en_bin, 2'h0, cfg_ff.thr_bin};
                    smsc_pkg::SMSC_OFF_STAT: wb_dat_o <= {21'h0, 3'(state_ff),
                        CNT_W >= 8 ? 8'(low_cnt_ff >> (CNT_W - 8)) : 8'(low_cnt_ff)};
                    smsc_pkg::SMSC_OFF_DUTY: wb_dat_o <= {17'h0, cfg_ff.exit_duty,
                        1'b0, cfg_ff.entry_duty};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/smsc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module smsc_partner (
    input wire logic [1:0] en_res_i,
    input wire logic [1:0] thr_res_i,
    input wire logic remote_closed_i,
    input wire logic en_src_i,
    input wire logic thr_src_i,
    output logic [1:0] en_bin_o,
    output logic [1:0] thr_bin_o,
    output logic en_high_o,
    output logic en_low_o
);
    // enable strap level.
    // Without source current the comparators read nothing useful, so show a wrong bin.
    assign en_bin_o = remote_closed_i ? 2'h0 : (en_src_i ? en_res_i : ~en_res_i);
    assign thr_bin_o = thr_src_i ? thr_res_i : ~thr_res_i;
    assign en_high_o = !remote_closed_i;
    assign en_low_o = remote_closed_i;
endmodule
`default_nettype wire

// *** bench/smsc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module smsc_assertions #(
    parameter int CONFIRM_CYCLES = smsc_pkg::SMSC_SLEEP_CONFIRM
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic half_cycle_i,
    input wire logic [6:0] duty_i,
    input wire logic primary_stop_i,
    input wire logic enable_low_i,
    input wire logic enable_strap_current_o,
    input wire logic enable_run_current_o,
    input wire logic threshold_strap_current_o,
    input wire logic drive_enable_o,
    input wire logic low_power_o,
    input wire logic sleep_en_o,
    input wire logic [6:0] burst_exit_duty_o
);
    int low_cnt_ff;
    logic above_ff;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Counts against the highest entry duty, so it is an upper bound on the low count for any table.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_ff <= 0;
        end else if (half_cycle_i) begin
            low_cnt_ff <= (duty_i < smsc_pkg::SMSC_T1_ENTRY) ? low_cnt_ff + 1 : 0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            above_ff <= 1'b0;
        end else if (half_cycle_i) begin
            above_ff <= duty_i > burst_exit_duty_o;
        end
    end
    start_sample_a: assert property ($rose(supply_ok_i) |-> ##[1:2] enable_strap_current_o)
        else $error("strap sampling did not start");
    src_excl_a: assert property (enable_strap_current_o |-> !enable_run_current_o)
        else $error("run current on while sampling");
    src_release_a: assert property ($fell(enable_strap_current_o) |-> ##[0:1]
        (enable_run_current_o && !threshold_strap_current_o))
        else $error("strap sources not released");
    cfg_hold_a: assert property (supply_ok_i && enable_run_current_o &&
        $past(enable_run_current_o) && !$past(enable_strap_current_o, 2)
        |-> $stable(burst_exit_duty_o) && $stable(sleep_en_o))
        else $error("latched setting changed in run");
    sleep_confirm_a: assert property ($rose(low_power_o) && sleep_en_o &&
        $past(supply_ok_i) && !$past(enable_low_i) && !$past(primary_stop_i)
        |-> low_cnt_ff >= CONFIRM_CYCLES)
        else $error("sleep entered too early");
    nosleep_cause_a: assert property ($rose(low_power_o) && !sleep_en_o &&
        supply_ok_i && $past(supply_ok_i) |-> $past(primary_stop_i) || $past(enable_low_i)
        || $past(primary_stop_i, 2) || $past(enable_low_i, 2))
        else $error("low power without cause");
    remote_off_a: assert property (enable_low_i && enable_run_current_o && supply_ok_i
        |-> ##[1:4] (low_power_o && !drive_enable_o))
        else $error("remote off ignored");
    stop_off_a: assert property (primary_stop_i && enable_run_current_o && supply_ok_i
        |-> ##[1:4] low_power_o)
        else $error("primary stop ignored");
    resume_duty_a: assert property ($rose(drive_enable_o) &&
        $past(enable_run_current_o, 2) |-> above_ff || $past(above_ff))
        else $error("resumed below exit duty");
    power_cmpl_a: assert property (drive_enable_o != low_power_o)
        else $error("drive and low power not complementary");
    sleep_seen_c: cover property (sleep_en_o && $rose(low_power_o));
    remote_seen_c: cover property (enable_low_i && low_power_o);
    stop_seen_c: cover property (!sleep_en_o && primary_stop_i && low_power_o);
endmodule
bind smsc_top smsc_assertions #(.CONFIRM_CYCLES(CONFIRM_CYCLES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i), .half_cycle_i(half_cycle_i),
    .duty_i(duty_i), .primary_stop_i(primary_stop_i), .enable_low_i(enable_low_i),
    .enable_strap_current_o(enable_strap_current_o),
    .enable_run_current_o(enable_run_current_o),
    .threshold_strap_current_o(threshold_strap_current_o), .drive_enable_o(drive_enable_o),
    .low_power_o(low_power_o), .sleep_en_o(sleep_en_o), .burst_exit_duty_o(burst_exit_duty_o)
);
`default_nettype wire

// *** bench/smsc_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module smsc_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic supply = 1'b0, half = 1'b0, pstop = 1'b0, remote = 1'b0, req = 1'b0, we = 1'b0;
    logic [6:0] duty = 7'h00;
    logic [1:0] en_res = 2'h3, thr_res = 2'h3, en_bin, thr_bin;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, q, wb_dat_o;
    logic en_hi, en_lo, wb_ack_o, es_cur, run_cur, ts_cur, drive, lowp, slp;
    logic [6:0] bexit;
    int errors = 0, compares = 0;
    logic [6:0] ex [0:11] = '{7'h50, 7'h4B, 7'h41, 7'h3C, 7'h4B, 7'h46, 7'h3C, 7'h37,
        7'h50, 7'h4B, 7'h41, 7'h00};
    logic [6:0] ent [0:2] = '{7'h28, 7'h19, 7'h00};
    smsc_partner partner_u (.en_res_i(en_res), .thr_res_i(thr_res), .remote_closed_i(remote),
        .en_src_i(es_cur), .thr_src_i(ts_cur), .en_bin_o(en_bin), .thr_bin_o(thr_bin),
        .en_high_o(en_hi), .en_low_o(en_lo));
    smsc_top #(.CONFIRM_CYCLES(8), .SETTLE_CYCLES(2)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply), .half_cycle_i(half), .duty_i(duty),
        .primary_stop_i(pstop), .enable_high_i(en_hi), .enable_low_i(en_lo),
        .enable_strap_bin_i(en_bin), .threshold_strap_bin_i(thr_bin), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enable_strap_current_o(es_cur),
        .enable_run_current_o(run_cur), .threshold_strap_current_o(ts_cur),
        .drive_enable_o(drive), .low_power_o(lowp), .sleep_en_o(slp), .burst_exit_duty_o(bexit));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        adr <= a;
        we <= w;
        wdat <= d;
        req <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        req <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pump(input int k, input logic [6:0] d);
        duty <= d;
        repeat (k) begin
            half <= 1'b1;
            @(posedge clk_i);
            half <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    // Exit waits out the blanking half cycles after sleep entry, so give it room.
    task automatic wake();
        for (int n = 0; n < 40 && drive !== 1'b1; n++) begin
            pump(1, 7'h64);
        end
    endtask
    task automatic power_up(input logic [1:0] e, input logic [1:0] t);
        int n;
        n = 0;
        supply <= 1'b0;
        en_res <= e;
        thr_res <= t;
        remote <= 1'b0;
        repeat (4) @(posedge clk_i);
        supply <= 1'b1;
        while (es_cur !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        while (es_cur === 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
        `CHK("sources", 2'h1, {es_cur | ts_cur, run_cur})
    endtask
    task automatic remote_cycle();
        remote <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK("remote off", 2'h1, {drive, lowp})
        remote <= 1'b0;
        wake();
        `CHK("remote on", 1'b1, drive)
    endtask
    initial begin
        int k;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(smsc_pkg::SMSC_OFF_CTRL, 1'b0, 32'h0, q);
        `CHK("ctrl reset", smsc_pkg::SMSC_CTRL_RESET, q)
        wb(smsc_pkg::SMSC_OFF_CTRL, 1'b1, 32'h1, q);
        wb(smsc_pkg::SMSC_OFF_CTRL, 1'b0, 32'h0, q);
        `CHK("ctrl standby", 32'h1, q)
        wb(4'h2, 1'b0, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        wb(smsc_pkg::SMSC_OFF_CTRL, 1'b1, 32'h0, q);
        for (int e = 0; e < 4; e++) begin
            for (int t = 0; t < 4; t++) begin
                k = (e == 3) ? 8 : (e == 2) ? 4 : 0;
                power_up(2'(e), 2'(t));
                `CHK("exit duty", ex[k + t], bexit)
                `CHK("sleep en", e != 3, slp)
                wb(smsc_pkg::SMSC_OFF_DUTY, 1'b0, 32'h0, q);
                `CHK("duty reg", {ex[k + t], ent[k / 4]}, {q[14:8], q[6:0]})
                wb(smsc_pkg::SMSC_OFF_CFG, 1'b0, 32'h0, q);
                `CHK("cfg reg", {1'b1, 2'(e), 2'(t)}, {q[9], q[5:4], q[1:0]})
            end
        end
        en_res <= 2'h0;
        thr_res <= 2'h0;
        repeat (5) @(posedge clk_i);
        `CHK("held cfg", 8'h00, {slp, bexit})
        $display("test straps done");
        wake();
        pump(12, 7'h05);
        `CHK("no light sleep", 1'b1, drive)
        pstop <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK("stop sleep", 1'b1, lowp)
        pstop <= 1'b0;
        wake();
        `CHK("stop resume", 1'b1, drive)
        remote_cycle();
        $display("test nosleep done");
        power_up(2'h0, 2'h1);
        wake();
        pump(7, 7'h1E);
        pump(1, 7'h32);
        pump(7, 7'h1E);
        `CHK("not yet", 1'b1, drive)
        pump(2, 7'h1E);
        `CHK("sleep entry", 1'b1, lowp)
        pump(12, 7'h46);
        `CHK("below exit", 1'b1, lowp)
        wake();
        `CHK("exit", 1'b1, drive)
        remote_cycle();
        $display("test table done");
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
